// File: hw/nds_map.svh
`ifndef NDS_MAP_SVH
`define NDS_MAP_SVH

// ----------------------------------------
// software register offsets and fields
// ----------------------------------------
`define NDS_REG_CTRL 8'h00
`define NDS_REG_CFG 8'h04
`define NDS_REG_BLK 8'h08
`define NDS_REG_STAT 8'h0c
`define NDS_REG_BADCNT 8'h10
`define NDS_CTRL_OP 2:0
`define NDS_CFG_DRV 1:0
`define NDS_CFG_WP 8
`define NDS_BLK_NUM 9:0
`define NDS_ST_BUSY 0
`define NDS_ST_TIMEOUT 1
`define NDS_ST_ERR 2
`define NDS_ST_BAD 3
`define NDS_ST_REFUSED 4
`define NDS_ST_BADLIM 5
`define NDS_ST_SCANOK 6
`define NDS_ST_WP 7
`define NDS_ST_DRV 9:8
`define NDS_ST_SBYTE 23:16
`define NDS_ST_OP 26:24
`define NDS_BADCNT_F 10:0

// ----------------------------------------
// device command bytes and status values
// ----------------------------------------
`define NDS_CMD_DRV 8'hb8
`define NDS_CMD_RESET 8'hff
`define NDS_CMD_STATUS 8'h70
`define NDS_CMD_READ1 8'h00
`define NDS_CMD_READ2 8'h30
`define NDS_CMD_ERASE1 8'h60
`define NDS_CMD_ERASE2 8'hd0
`define NDS_DRV_LSB 2
`define NDS_DRV_F 3:2
`define NDS_SR_READY 6
`define NDS_SR_FAIL 0
`define NDS_SR_RST_WP_HI 8'he0
`define NDS_SR_RST_WP_LO 8'h60
`define NDS_COL_X8 16'h0800
`define NDS_COL_X16 16'h0400
`define NDS_MARK_X8 8'hff
`define NDS_MARK_X16 16'hffff
`define NDS_PAGE_BITS 6
`define NDS_BOOT_BLK 10'h000
`define NDS_BLOCKS 11'h400
`define NDS_MIN_GOOD 11'h3ec

// ----------------------------------------
// timing, ns at a 50 ns clock
// ----------------------------------------
`define NDS_CLK_NS 50
`define NDS_SETUP_NS 30
`define NDS_WPIO_NS 50
`define NDS_WHIO_NS 50
`define NDS_RPIO_NS 250
`define NDS_WHRIO_NS 100
`define NDS_WB_NS 200
`define NDS_RST_MAX_NS 1000000
`define NDS_SYNC_CYC 2
`define NDS_MIN_CYC(ns) (((ns) + `NDS_CLK_NS - 1) / `NDS_CLK_NS)

`endif

// File: hw/nds_pkg.sv
package nds_pkg;

	typedef enum logic [2:0] {
		NDS_OP_NONE = 3'h0,
		NDS_OP_DRV_WR = 3'h1,
		NDS_OP_DRV_RD = 3'h2,
		NDS_OP_RESET = 3'h3,
		NDS_OP_SCAN = 3'h4,
		NDS_OP_ERASE = 3'h5
	} nds_op_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_C1 = 4'h1,
		S_AD = 4'h2,
		S_DI = 4'h3,
		S_C2 = 4'h4,
		S_BSY = 4'h5,
		S_SC = 4'h6,
		S_DO = 4'h7,
		S_FIN = 4'h8
	} nds_state_t;

	typedef enum logic [1:0] {K_CMD = 2'h0, K_ADDR = 2'h1, K_DIN = 2'h2, K_DOUT = 2'h3} nds_kind_t;
	typedef enum logic [1:0] {P_IDLE = 2'h0, P_SET = 2'h1, P_LOW = 2'h2, P_HIGH = 2'h3} nds_phase_t;

	typedef struct packed {logic wr; logic rd; logic [7:0] addr; logic [31:0] wdata;} nds_sw_req_t;
	typedef struct packed {logic go; nds_kind_t kind; logic [15:0] data;} nds_seq_req_t;
	typedef struct packed {logic done; logic [15:0] rdata;} nds_seq_rsp_t;
	typedef struct packed {
		logic cle; logic ale; logic we_n; logic re_n; logic io_oe; logic [15:0] io_out;
	} nds_bus_pins_t;
	typedef struct packed {logic ce_n; logic wp_n; nds_bus_pins_t bus;} nds_pins_t;

	typedef struct packed {
		nds_phase_t ph; logic [3:0] cnt; nds_kind_t kind; nds_bus_pins_t pins;
		nds_seq_rsp_t rsp; logic [15:0] io_m; logic [15:0] io_s;
	} nds_seq_st_t;

	typedef struct packed {
		nds_state_t state; nds_op_t op; logic issued; logic [1:0] step; logic page;
		logic [15:0] wcnt; logic rb_m; logic rb_s; logic ce_n; logic wp_n;
		nds_seq_req_t req; logic [1:0] drv_set; logic [1:0] drv_rb; logic [9:0] blk;
		logic scan_ok; logic [9:0] scan_blk; logic [7:0] stat_byte; logic stat_seen;
		logic busy; logic err_to; logic err_stat; logic bad; logic refused;
		logic [10:0] bad_cnt; logic bad_lim; logic [31:0] rd_data;
	} nds_ctl_st_t;

endpackage : nds_pkg

// File: hw/nds_bus_seq.sv
`timescale 1ns/1ps
`include "nds_map.svh"
module nds_bus_seq
	import nds_pkg::*;
(
	input logic core_clk,
	input logic sys_rst,
	input nds_seq_req_t req,
	input logic [15:0] io_in,
	output nds_bus_pins_t bus,
	output nds_seq_rsp_t rsp
);
	localparam logic [3:0] SET_W = 4'(`NDS_MIN_CYC(`NDS_SETUP_NS));
	localparam logic [3:0] LOW_W = 4'(`NDS_MIN_CYC(`NDS_WPIO_NS));
	localparam logic [3:0] HIGH_W = 4'(`NDS_MIN_CYC(`NDS_WHIO_NS));
	localparam logic [3:0] RD_GAP = 4'(`NDS_MIN_CYC(`NDS_WHRIO_NS));
	// one spare cycle so the synchronised sample lands past the access time
	localparam logic [3:0] RD_LOW = 4'(`NDS_MIN_CYC(`NDS_RPIO_NS) + `NDS_SYNC_CYC + 1);

	nds_seq_st_t st, nx;

	function automatic logic hit(input logic [3:0] cnt, input logic [3:0] len);
		hit = (cnt == len - 4'h1);
	endfunction : hit

	always_comb
	begin
		nx = st;
		nx.rsp.done = 1'b0;
		nx.io_m = io_in;
		nx.io_s = st.io_m;
		unique case (st.ph)
			P_IDLE:
			if (req.go)
			begin
				nx.ph = P_SET;
				nx.cnt = 4'h0;
				nx.kind = req.kind;
				nx.pins.cle = (req.kind == K_CMD);
				nx.pins.ale = (req.kind == K_ADDR);
				nx.pins.io_oe = (req.kind != K_DOUT);
				nx.pins.io_out = req.data;
			end
			P_SET:
			if (hit(st.cnt, (st.kind == K_DOUT) ? RD_GAP : SET_W))
			begin
				nx.cnt = 4'h0;
				nx.ph = P_LOW;
				if (st.kind == K_DOUT)
					nx.pins.re_n = 1'b0;
				else
					nx.pins.we_n = 1'b0;
			end
			else
				nx.cnt = st.cnt + 4'h1;
			P_LOW:
			if (hit(st.cnt, (st.kind == K_DOUT) ? RD_LOW : LOW_W))
			begin
				nx.cnt = 4'h0;
				nx.ph = P_HIGH;
				nx.pins.we_n = 1'b1;
				nx.pins.re_n = 1'b1;
				if (st.kind == K_DOUT)
					nx.rsp.rdata = st.io_s;
			end
			else
				nx.cnt = st.cnt + 4'h1;
			P_HIGH:
			if (hit(st.cnt, HIGH_W))
			begin
				nx.ph = P_IDLE;
				nx.pins.cle = 1'b0;
				nx.pins.ale = 1'b0;
				nx.pins.io_oe = 1'b0;
				nx.pins.io_out = 16'h0000;
				nx.rsp.done = 1'b1;
			end
			else
				nx.cnt = st.cnt + 4'h1;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			st <= '0;
			st.pins.we_n <= 1'b1;
			st.pins.re_n <= 1'b1;
		end
		else
			st <= nx;
	end

	assign bus = st.pins;
	assign rsp = st.rsp;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_we_pulse_width: assert property ($fell(bus.we_n) |=> bus.we_n && !bus.io_oe == 1'b0)
		else $error("write strobe width wrong");
	a_re_pulse_width: assert property ($fell(bus.re_n) |-> !bus.re_n [*8] ##1 bus.re_n)
		else $error("read strobe width wrong");
	c_read_cycle: cover property ($fell(bus.re_n) ##[1:20] rsp.done);

endmodule : nds_bus_seq

// File: hw/nds_ctrl.sv
// Functional notes
// - code bits 3:2: full, 3/4, 1/2, 1/4
// - other data bits zero out, masked in
// - check spare markers before any erase (block zero is erased here without a scan)
// - read status after erase, check fail
// - host ECC per 528 bytes recommended
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "nds_map.svh"
module nds_ctrl
	import nds_pkg::*;
#(
	parameter int IO_W = 8,
	parameter int BUSY_TO_CYC = `NDS_RST_MAX_NS / `NDS_CLK_NS
)
(
	input logic core_clk,
	input logic sys_rst,
	input nds_sw_req_t sw_req,
	output logic [31:0] sw_rdata,
	output nds_pins_t pins,
	input logic [15:0] io_in,
	input logic rb_n
);
	localparam logic [10:0] BAD_MAX = `NDS_BLOCKS - `NDS_MIN_GOOD;
	localparam logic [15:0] WB_CYC = 16'(`NDS_MIN_CYC(`NDS_WB_NS));
	localparam logic [15:0] TO_LAST = 16'(BUSY_TO_CYC - 1);
	localparam logic [15:0] SPARE_COL = (IO_W == 16) ? `NDS_COL_X16 : `NDS_COL_X8;

	generate
		if (IO_W != 8 && IO_W != 16)
		begin : g_bad_width
			$error("IO_W must be 8 or 16");
		end
		if (BUSY_TO_CYC < 16 || BUSY_TO_CYC > 65535)
		begin : g_bad_timeout
			$error("BUSY_TO_CYC out of range");
		end
	endgenerate

	nds_ctl_st_t st, next_st;
	nds_seq_rsp_t seq_rsp;
	nds_bus_pins_t seq_bus;
	nds_op_t wr_op;
	logic [15:0] row;
	logic erase_ok;
	logic bus_done;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] addr_byte(input logic [1:0] idx, input logic [15:0] col,
		input logic [15:0] r);
		unique case (idx)
			2'h0: addr_byte = col[7:0];
			2'h1: addr_byte = col[15:8];
			2'h2: addr_byte = r[7:0];
			2'h3: addr_byte = r[15:8];
		endcase
	endfunction : addr_byte

	function automatic logic marker_good(input logic [15:0] d);
		if (IO_W == 16)
			marker_good = (d == `NDS_MARK_X16);
		else
			marker_good = (d[7:0] == `NDS_MARK_X8);
	endfunction : marker_good

	nds_bus_seq u_seq (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.req(st.req),
		.io_in(io_in),
		.bus(seq_bus),
		.rsp(seq_rsp)
	);

	assign wr_op = nds_op_t'(sw_req.wdata[`NDS_CTRL_OP]);
	assign row = {st.blk, {(`NDS_PAGE_BITS - 1){1'b0}}, st.page};
	assign bus_done = st.issued && seq_rsp.done;
	// block zero needs no marker scan; others only while the last scan was a clean one of this block
	assign erase_ok = st.wp_n && ((st.blk == `NDS_BOOT_BLK)
		|| (st.scan_ok && st.scan_blk == st.blk));

	// ----------------------------------------
	// register port and sequencing
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.rb_m = rb_n;
		next_st.rb_s = st.rb_m;
		next_st.req.go = 1'b0;
		next_st.rd_data = 32'h0000_0000;
		next_st.bad_lim = (st.bad_cnt > BAD_MAX);

		if (sw_req.wr)
		begin
			case (sw_req.addr)
				`NDS_REG_CTRL:
				if (wr_op != NDS_OP_NONE && wr_op <= NDS_OP_ERASE)
				begin
					if (st.busy || (wr_op == NDS_OP_ERASE && !erase_ok))
						next_st.refused = 1'b1;
					else
					begin
						next_st.op = wr_op;
						next_st.busy = 1'b1;
						next_st.ce_n = 1'b0;
						next_st.issued = 1'b0;
						next_st.page = 1'b0;
						next_st.err_to = 1'b0;
						next_st.err_stat = 1'b0;
						next_st.refused = 1'b0;
						next_st.stat_seen = 1'b0;
						next_st.state = S_C1;
						if (wr_op == NDS_OP_SCAN)
						begin
							next_st.bad = 1'b0;
							next_st.scan_ok = 1'b0;
							if (st.blk == `NDS_BOOT_BLK)
							begin
								next_st.scan_ok = 1'b1;
								next_st.scan_blk = `NDS_BOOT_BLK;
								next_st.ce_n = 1'b1;
								next_st.state = S_FIN;
							end
						end
					end
				end
				`NDS_REG_CFG:
				begin
					next_st.drv_set = sw_req.wdata[`NDS_CFG_DRV];
					next_st.wp_n = sw_req.wdata[`NDS_CFG_WP];
				end
				`NDS_REG_BLK:
				if (st.busy)
					next_st.refused = 1'b1;
				else
					next_st.blk = sw_req.wdata[`NDS_BLK_NUM];
				default: ;
			endcase
		end

		if (sw_req.rd)
		begin
			case (sw_req.addr)
				`NDS_REG_CTRL: next_st.rd_data[`NDS_CTRL_OP] = st.op;
				`NDS_REG_CFG:
				begin
					next_st.rd_data[`NDS_CFG_DRV] = st.drv_set;
					next_st.rd_data[`NDS_CFG_WP] = st.wp_n;
				end
				`NDS_REG_BLK: next_st.rd_data[`NDS_BLK_NUM] = st.blk;
				`NDS_REG_STAT:
				begin
					next_st.rd_data[`NDS_ST_BUSY] = st.busy;
					next_st.rd_data[`NDS_ST_TIMEOUT] = st.err_to;
					next_st.rd_data[`NDS_ST_ERR] = st.err_stat;
					next_st.rd_data[`NDS_ST_BAD] = st.bad;
					next_st.rd_data[`NDS_ST_REFUSED] = st.refused;
					next_st.rd_data[`NDS_ST_BADLIM] = st.bad_lim;
					next_st.rd_data[`NDS_ST_SCANOK] = st.scan_ok;
					next_st.rd_data[`NDS_ST_WP] = st.wp_n;
					next_st.rd_data[`NDS_ST_DRV] = st.drv_rb;
					next_st.rd_data[`NDS_ST_SBYTE] = st.stat_byte;
					next_st.rd_data[`NDS_ST_OP] = st.op;
				end
				`NDS_REG_BADCNT: next_st.rd_data[`NDS_BADCNT_F] = st.bad_cnt;
				default: ;
			endcase
		end

		// issue one bus cycle at a time (S_AD repeats once per address byte), then wait for its completion
		if (!st.issued && (st.state == S_C1 || st.state == S_AD || st.state == S_DI
			|| st.state == S_C2 || st.state == S_SC || st.state == S_DO))
		begin
			next_st.issued = 1'b1;
			next_st.req.go = 1'b1;
			next_st.req.data = 16'h0000;
		end

		unique case (st.state)
			S_IDLE: ;
			S_C1:
			begin
				next_st.req.kind = K_CMD;
				unique case (st.op)
					NDS_OP_DRV_WR, NDS_OP_DRV_RD: next_st.req.data[7:0] = `NDS_CMD_DRV;
					NDS_OP_RESET: next_st.req.data[7:0] = `NDS_CMD_RESET;
					NDS_OP_SCAN: next_st.req.data[7:0] = `NDS_CMD_READ1;
					NDS_OP_ERASE, NDS_OP_NONE: next_st.req.data[7:0] = `NDS_CMD_ERASE1;
				endcase
				if (bus_done)
				begin
					next_st.issued = 1'b0;
					next_st.wcnt = 16'h0000;
					unique case (st.op)
						NDS_OP_DRV_WR: next_st.state = S_DI;
						NDS_OP_DRV_RD: next_st.state = S_DO;
						NDS_OP_RESET: next_st.state = S_BSY;
						NDS_OP_SCAN: {next_st.state, next_st.step} = {S_AD, 2'h0};
						NDS_OP_ERASE, NDS_OP_NONE: {next_st.state, next_st.step} = {S_AD, 2'h2};
					endcase
				end
			end
			S_AD:
			begin
				next_st.req.kind = K_ADDR;
				next_st.req.data[7:0] = addr_byte(st.step, SPARE_COL, row);
				if (bus_done)
				begin
					next_st.issued = 1'b0;
					next_st.step = st.step + 2'h1;
					if (st.step == 2'h3)
						next_st.state = S_C2;
				end
			end
			S_DI:
			begin
				next_st.req.kind = K_DIN;
				next_st.req.data = 16'(st.drv_set) << `NDS_DRV_LSB;
				if (bus_done)
				begin
					next_st.issued = 1'b0;
					next_st.drv_rb = st.drv_set;
					next_st.state = S_FIN;
				end
			end
			S_C2:
			begin
				next_st.req.kind = K_CMD;
				next_st.req.data[7:0] = (st.op == NDS_OP_SCAN) ? `NDS_CMD_READ2 : `NDS_CMD_ERASE2;
				if (bus_done)
				begin
					next_st.issued = 1'b0;
					next_st.wcnt = 16'h0000;
					next_st.state = S_BSY;
				end
			end
			S_BSY:
			begin
				next_st.wcnt = st.wcnt + 16'h0001;
				if (st.wcnt == TO_LAST)
				begin
					next_st.err_to = 1'b1;
					next_st.state = S_FIN;
				end
				else if (st.wcnt >= WB_CYC && st.rb_s)
					next_st.state = (st.op == NDS_OP_SCAN) ? S_DO : S_SC;
			end
			S_SC:
			begin
				next_st.req.kind = K_CMD;
				next_st.req.data[7:0] = `NDS_CMD_STATUS;
				if (bus_done)
				begin
					next_st.issued = 1'b0;
					next_st.stat_seen = 1'b1;
					next_st.state = S_DO;
				end
			end
			S_DO:
			begin
				next_st.req.kind = K_DOUT;
				if (bus_done)
				begin
					next_st.issued = 1'b0;
					next_st.state = S_FIN;
					unique case (st.op)
						NDS_OP_DRV_RD: next_st.drv_rb = seq_rsp.rdata[`NDS_DRV_F];
						NDS_OP_RESET:
						begin
							next_st.stat_byte = seq_rsp.rdata[7:0];
							next_st.err_stat = seq_rsp.rdata[7:0] != (st.wp_n ?
								`NDS_SR_RST_WP_HI : `NDS_SR_RST_WP_LO);
						end
						NDS_OP_SCAN:
						if (!marker_good(seq_rsp.rdata))
						begin
							next_st.bad = 1'b1;
							if (st.bad_cnt != '1)
								next_st.bad_cnt = st.bad_cnt + 11'h001;
						end
						else if (!st.page)
						begin
							next_st.page = 1'b1;
							next_st.state = S_C1;
						end
						else
						begin
							next_st.scan_ok = 1'b1;
							next_st.scan_blk = st.blk;
						end
						NDS_OP_ERASE, NDS_OP_DRV_WR, NDS_OP_NONE:
						begin
							next_st.stat_byte = seq_rsp.rdata[7:0];
							next_st.err_stat = seq_rsp.rdata[`NDS_SR_FAIL]
								|| !seq_rsp.rdata[`NDS_SR_READY];
						end
					endcase
				end
			end
			S_FIN:
			begin
				next_st.busy = 1'b0;
				next_st.ce_n = 1'b1;
				next_st.state = S_IDLE;
			end
			default: next_st.state = S_IDLE;
		endcase
	end

	// protected and deselected until software says otherwise
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			st <= '0;
			st.ce_n <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign sw_rdata = st.rd_data;
	assign pins.ce_n = st.ce_n;
	assign pins.wp_n = st.wp_n;
	assign pins.bus = seq_bus;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_drv_cmd_code: assert property (st.state == S_C1 && st.req.go
		&& (st.op == NDS_OP_DRV_WR || st.op == NDS_OP_DRV_RD) |-> st.req.data == 16'h00b8)
		else $error("drive command code wrong");
	a_drv_code_bits: assert property (st.state == S_DI && st.req.go
		|-> st.req.data == {12'h000, st.drv_set, 2'h0})
		else $error("drive code not on bits 3:2");
	a_drv_default: assert property ($fell(sys_rst) |-> st.drv_rb == 2'h0 && st.drv_set == 2'h0)
		else $error("drive default not full");
	a_drv_mask: assert property (st.state == S_DO && bus_done && st.op == NDS_OP_DRV_RD
		|=> st.drv_rb == $past(seq_rsp.rdata[3:2]) && st.state == S_FIN)
		else $error("drive readback not masked");
	a_erase_wp: assert property (st.state == S_C1 && st.op == NDS_OP_ERASE |-> st.wp_n)
		else $error("erase issued while protected");
	a_erase_scan: assert property ($rose(st.busy) && st.op == NDS_OP_ERASE
		|-> st.blk == 10'h000 || (st.scan_ok && st.scan_blk == st.blk))
		else $error("erase without marker check");
	a_erase_status: assert property (st.state == S_FIN && st.op == NDS_OP_ERASE
		&& !st.err_to |-> st.stat_seen)
		else $error("erase finished without status");
	a_bad_limit: assert property (st.bad_cnt > 11'h014 |=> st.bad_lim)
		else $error("bad block limit not flagged");
	a_boot_skip: assert property (sw_req.wr && sw_req.addr == 8'h00 && !st.busy
		&& wr_op == NDS_OP_SCAN && st.blk == 10'h000
		|=> st.state == S_FIN ##1 st.state == S_IDLE && st.scan_ok)
		else $error("boot block scan not skipped");
	a_reset_expect: assert property (st.state == S_DO && bus_done && st.op == NDS_OP_RESET
		|=> st.err_stat == ($past(seq_rsp.rdata[7:0]) != ($past(st.wp_n) ? 8'he0 : 8'h60)))
		else $error("reset status check wrong");
	a_drv_pair: assert property (st.state == S_C1 && bus_done && st.op == NDS_OP_DRV_WR
		|=> st.state == S_DI ##1 st.req.go && st.req.kind == K_DIN)
		else $error("drive write not one data cycle");

	c_drv_write: cover property (st.state == S_DI && bus_done);
	c_drv_read: cover property (st.state == S_DO && bus_done && st.op == NDS_OP_DRV_RD);
	c_scan_bad: cover property ($rose(st.bad));
	c_erase_done: cover property (st.state == S_FIN && st.op == NDS_OP_ERASE && !st.err_stat);

endmodule : nds_ctrl

// File: verif/nds_flash_model.sv
`timescale 1ns/1ps
module nds_flash_model
	import nds_pkg::*;
(
	input nds_pins_t pins,
	output logic [15:0] io_in,
	output logic rb_n,
	input logic slow,
	input logic hang,
	input logic fail_erase
);
	// ----------------------------------------
	// device state
	// ----------------------------------------
	logic [7:0] cmd = 8'h00;
	logic [7:0] adr [4];
	logic [2:0] acnt = 3'h0;
	logic [1:0] drv = 2'h0;
	logic [7:0] din = 8'h00;
	logic [7:0] stat = 8'he0;
	logic [15:0] io_q = 16'h0000;
	int erases = 0;
	event kick;
	assign io_in = io_q;

	// only blocks 5 and 7 carry bad marks, block 0 never
	function automatic logic [7:0] marker(input logic [15:0] row);
		if (row[15:6] == 10'h005 && row[0])
			return 8'h0f;
		if (row[15:6] == 10'h007 && !row[0])
			return 8'h00;
		return 8'hff;
	endfunction : marker

	// ----------------------------------------
	// latch on rising write strobe
	// ----------------------------------------
	always @(posedge pins.bus.we_n)
		if (pins.ce_n === 1'b0)
		begin
			if (pins.bus.cle)
			begin
				cmd = pins.bus.io_out[7:0];
				acnt = 3'h0;
				if (cmd == 8'hff)
				begin
					stat = pins.wp_n ? 8'he0 : 8'h60;
					->kick;
				end
				if (cmd == 8'h30)
					->kick;
				if (cmd == 8'hd0 && pins.wp_n)
				begin
					erases++;
					stat = {7'h70, fail_erase};
					->kick;
				end
				else if (cmd == 8'hd0)
					stat = 8'h60;
			end
			else if (pins.bus.ale)
			begin
				adr[acnt[1:0]] = pins.bus.io_out[7:0];
				acnt++;
			end
			else if (cmd == 8'hb8)
			begin
				din = pins.bus.io_out[7:0];
				drv = din[3:2];
			end
		end

	// ----------------------------------------
	// read data, released bus shows inverse
	// ----------------------------------------
	always @(negedge pins.bus.re_n)
		if (pins.ce_n === 1'b0)
		begin
			if (cmd == 8'hb8)
				io_q <= {8'h00, 4'ha, drv, 2'h1};
			else if (cmd == 8'h30)
				io_q <= {8'h00, marker({adr[3], adr[2]})};
			else
				io_q <= {8'h00, stat};
		end
	always @(posedge pins.bus.re_n)
		io_q <= ~io_q;

	// busy line has a pull-up; hang holds it low
	initial
		rb_n = 1'b1;
	always
	begin
		@(kick);
		rb_n = 1'b0;
		#(slow ? 2000 : 300);
		wait (!hang);
		rb_n = 1'b1;
	end
endmodule : nds_flash_model

// File: verif/tb_nand_drive_strength_and_protect.sv
`timescale 1ns/1ps
module tb_nand_drive_strength_and_protect
	import nds_pkg::*;
;
	logic core_clk = 1'b0;
	logic sys_rst;
	nds_sw_req_t sw_req;
	logic [31:0] sw_rdata;
	nds_pins_t pins;
	logic [15:0] io_in;
	logic rb_n;
	logic slow;
	logic hang;
	logic fail_erase;
	int failures = 0;
	int total_checks = 0;

	always #25 core_clk = ~core_clk;

	nds_ctrl #(.IO_W(8), .BUSY_TO_CYC(64)) dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .sw_req(sw_req), .sw_rdata(sw_rdata),
		.pins(pins), .io_in(io_in), .rb_n(rb_n));
	nds_flash_model fm (
		.pins(pins), .io_in(io_in), .rb_n(rb_n), .slow(slow), .hang(hang),
		.fail_erase(fail_erase));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		sw_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		sw_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		sw_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge core_clk);
		sw_req.rd <= 1'b0;
		#1 d = sw_rdata;
	endtask : rd
	// start an op, poll until busy drops; the watchdog bounds a hang
	task automatic run(input logic [2:0] op, output logic [31:0] s);
		wr(8'h00, {29'h0, op});
		repeat (2) @(posedge core_clk);
		do
			rd(8'h0c, s);
		while (s[0] !== 1'b0);
	endtask : run
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [31:0] s;
		rd(8'h0c, s);
		check(32'(s[9:8]), 32'h0, "default drive");
		rd(8'h14, s);
		check(s, 32'h0, "unmapped read");
		for (int w = 0; w < 2; w++)
		begin
			wr(8'h04, {23'h0, w[0], 8'h00});
			run(3'h3, s);
			check(32'(s[23:16]), w ? 32'he0 : 32'h60, "status after reset");
			check(32'(s[2:1]), 32'h0, "reset ok");
		end
	endtask : t_reset
	task automatic t_drive;
		logic [31:0] s;
		for (int c = 1; c < 5; c++)
		begin
			wr(8'h04, {23'h0, 1'b1, 6'h3f, c[1:0]});
			run(3'h1, s);
			check(32'(fm.cmd), 32'hb8, "drive command");
			check(32'(fm.drv), 32'(c[1:0]), "device code");
			check(32'(fm.din), 32'(c[1:0]) << 2, "other bits zero");
			run(3'h2, s);
			check(32'(s[9:8]), 32'(c[1:0]), "masked readback");
		end
	endtask : t_drive
	task automatic t_scan;
		logic [31:0] s;
		logic [9:0] blks [4] = '{10'h005, 10'h007, 10'h000, 10'h003};
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h08, 32'(blks[i]));
			run(3'h4, s);
			check(32'(s[3]), i < 2 ? 32'h1 : 32'h0, "bad marker");
			check(32'(s[6]), i < 2 ? 32'h0 : 32'h1, "scan ok");
			rd(8'h10, s);
			check(s, i < 1 ? 32'h1 : 32'h2, "bad count");
		end
		check({16'h0, fm.adr[1], fm.adr[0]}, 32'h0800, "spare column");
		check(32'(fm.adr[2]), 32'hc1, "page one row");
	endtask : t_scan
	task automatic t_erase;
		logic [31:0] s;
		int n;
		n = fm.erases;
		slow <= 1'b1;
		run(3'h5, s);
		check(32'(s[2]), 32'h0, "erase pass");
		check(32'(fm.erases), 32'(n + 1), "erase reached device");
		slow <= 1'b0;
		fail_erase <= 1'b1;
		run(3'h5, s);
		check(32'(s[2]), 32'h1, "erase fail seen");
		fail_erase <= 1'b0;
		wr(8'h04, 32'h0);
		run(3'h5, s);
		check(32'(s[4]), 32'h1, "refused when protected");
		check(32'(fm.erases), 32'(n + 2), "no erase sent");
		wr(8'h04, 32'h100);
		wr(8'h08, 32'h5);
		run(3'h5, s);
		check(32'(s[4]), 32'h1, "unscanned refused");
		wr(8'h08, 32'h0);
		run(3'h5, s);
		check(32'(s[4:2]), 32'h0, "boot block erase");
	endtask : t_erase
	// rescans of a bad block recount, so the limit flag trips at 21
	task automatic t_badlim;
		logic [31:0] s;
		wr(8'h08, 32'h7);
		for (int k = 3; k <= 21; k++)
		begin
			run(3'h4, s);
			if (k >= 20)
				check(32'(s[5]), (k > 20) ? 32'h1 : 32'h0, "bad count limit");
		end
		rd(8'h10, s);
		check(s, 32'h15, "bad count after rescans");
	endtask : t_badlim
	task automatic t_hang;
		logic [31:0] s;
		hang <= 1'b1;
		run(3'h3, s);
		check(32'(s[1]), 32'h1, "busy timeout");
		hang <= 1'b0;
		repeat (20) @(posedge core_clk);
		run(3'h3, s);
		check(32'(s[2:1]), 32'h0, "flags cleared");
	endtask : t_hang
	task automatic t_midrst;
		logic [31:0] s;
		wr(8'h04, 32'h102);
		run(3'h1, s);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(8'h0c, s);
		check(32'(s[9:8]), 32'h0, "drive back to full");
		check(32'(pins.wp_n), 32'h0, "protect after reset");
		// host reset leaves the device's own code in place
		run(3'h2, s);
		check(32'(s[9:8]), 32'h2, "device code kept");
	endtask : t_midrst

	initial
	begin
		sw_req = '0;
		sys_rst = 1'b1;
		slow = 1'b0;
		hang = 1'b0;
		fail_erase = 1'b0;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_drive();
		t_scan();
		t_erase();
		t_badlim();
		t_hang();
		t_midrst();
		tally_and_finish();
	end

	// all ops together stay far below this span
	initial
	begin
		#(60000 * 50);
		failures++;
		tally_and_finish();
	end
endmodule : tb_nand_drive_strength_and_protect
